// file: logic/rppa_pkg.sv
// constants, types and helpers of the relay parameter and password access block
// assumes a 16-bit word register port and a single 25 MHz clock
package rppa_pkg;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int NSIG = 9;
    localparam int NEVT = 2 * NSIG;
    localparam int NSET = 5;
    localparam int NMEAS = 9;
    localparam int CW = 6;
    localparam int CNTW = 6;
    localparam int EVT_DEPTH = 60;
    localparam logic [CNTW-1:0] EVT_FULL = CNTW'(EVT_DEPTH);
    localparam logic [CNTW-1:0] PTR_LAST = CNTW'(EVT_DEPTH - 1);
    // register offsets
    localparam logic [AW-1:0] ADR_PWD_OPEN = 8'h00;
    localparam logic [AW-1:0] ADR_PWD_CLOSE = 8'h01;
    localparam logic [AW-1:0] ADR_PWD_STAT = 8'h02;
    localparam logic [AW-1:0] ADR_EVT_DATA = 8'h03;
    localparam logic [AW-1:0] ADR_EVT_CNT = 8'h04;
    localparam logic [AW-1:0] ADR_EVT_MASK = 8'h05;
    localparam logic [AW-1:0] ADR_STAT_ACT = 8'h06;
    localparam logic [AW-1:0] ADR_STAT_MEM = 8'h07;
    localparam logic [AW-1:0] ADR_ANG_BASE = 8'h10;
    localparam logic [AW-1:0] ADR_PCT_BASE = 8'h20;
    localparam logic [AW-1:0] ADR_SET_BASE = 8'h30;
    // field positions
    localparam int POS_OPEN = 0;
    localparam int POS_LOCK = 1;
    localparam int POS_FAIL = 2;
    localparam int POS_VALID = 8;
    // event codes and values
    localparam logic [CW-1:0] EVT_RESTART = 6'h32;
    localparam logic [CW-1:0] EVT_OVERFLOW = 6'h33;
    localparam logic [9:0] PWD_DEFAULT = 10'h001;
    localparam logic [9:0] PWD_MIN = 10'h001;
    localparam logic [9:0] PWD_MAX = 10'h3e7;
    localparam logic [9:0] PWD_LOCKVAL = 10'h000;
    localparam logic [2:0] FAIL_LIMIT = 3'h7;
    localparam logic [8:0] ANGLE_MAX = 9'h167;
    localparam logic [12:0] PCT_MAX = 13'h199a;
    localparam logic [NSIG-1:0] MASK_RST = 9'h1ff;
    localparam logic [7:0] SET_MIN [NSET] = '{8'h05, 8'h0a, 8'h05, 8'h07, 8'h0a};
    localparam logic [7:0] SET_MAX [NSET] = '{8'h32, 8'h32, 8'h1e, 8'h14, 8'h32};
    localparam logic [7:0] SET_RST [NSET] = SET_MIN;

    typedef enum logic [1:0] {PW_CLOSED, PW_OPEN, PW_LOCKED} rppa_pstate_t;

    function automatic logic rppaSetOk(input int idx, input logic [DW-1:0] v);
        return (v >= {8'h00, SET_MIN[idx]}) && (v <= {8'h00, SET_MAX[idx]});
    endfunction

    function automatic logic rppaPwdOk(input logic [DW-1:0] v);
        return (v >= {6'h00, PWD_MIN}) && (v <= {6'h00, PWD_MAX});
    endfunction

    function automatic logic rppaInWin(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                       input int n);
        return (int'(a) >= int'(b)) && (int'(a) < int'(b) + n);
    endfunction

    function automatic int rppaWinIdx(input logic [AW-1:0] a, input logic [AW-1:0] b);
        return int'(a) - int'(b);
    endfunction
endpackage

// file: logic/rppa_evt_buf.sv
// sixty-entry event code buffer in flip-flops, circular with an occupancy count
// assumes the writer never pushes while full
`timescale 1ns/1ps
module rppa_evt_buf
    import rppa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic push,
    input wire logic [CW-1:0] pushCode,
    input wire logic pop,
    output logic [CW-1:0] headCode,
    output logic [CNTW-1:0] count,
    output logic full,
    output logic empty
);
    logic [CW-1:0] mem_r [EVT_DEPTH];
    logic [CNTW-1:0] wrPtr_r;
    logic [CNTW-1:0] rdPtr_r;
    logic [CNTW-1:0] count_r;
    logic doPush;
    logic doPop;

    function automatic logic [CNTW-1:0] nextPtr(input logic [CNTW-1:0] p);
        return (p == PTR_LAST) ? '0 : p + 6'h01;
    endfunction

    assign full = (count_r == EVT_FULL);
    assign empty = (count_r == '0);
    assign count = count_r;
    assign headCode = mem_r[rdPtr_r];
    assign doPush = push && !full;
    assign doPop = pop && !empty;

    // storage has no reset; empty reads are masked by the count
    always_ff @(posedge mclk)
    begin
        if (doPush)
            mem_r[wrPtr_r] <= pushCode;
    end

    // pointers and occupancy
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (doPush)
                wrPtr_r <= nextPtr(wrPtr_r);
            if (doPop)
                rdPtr_r <= nextPtr(rdPtr_r);
            if (doPush && !doPop)
                count_r <= count_r + 6'h01;
            else if (doPop && !doPush)
                count_r <= count_r - 6'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_count_cap: assert property (count_r <= EVT_FULL)
        else $error("event count above capacity");
    a_push_count: assert property (doPush && !doPop |=> count_r == $past(count_r) + 6'h01)
        else $error("push did not grow count");
endmodule

// file: logic/rppa_stat_latch.sv
// actual-status and memorized flags for the protection and relay signals
// assumes signal inputs synchronous to mclk; memClr is a one-cycle register reset
`timescale 1ns/1ps
module rppa_stat_latch
    import rppa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NSIG-1:0] act,
    input wire logic memClr,
    output logic [NSIG-1:0] actQ,
    output logic [NSIG-1:0] memQ,
    output logic [NSIG-1:0] rise,
    output logic [NSIG-1:0] fall
);
    logic [NSIG-1:0] act_r;
    logic [NSIG-1:0] mem_r;

    assign actQ = act_r;
    assign memQ = mem_r;
    assign rise = act & ~act_r;
    assign fall = ~act & act_r;

    // actual state: 1 active, 0 inactive; memorized bit survives a clear while active
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            act_r <= '0;
            mem_r <= '0;
        end
        else
        begin
            act_r <= act;
            mem_r <= (mem_r & ~{NSIG{memClr}}) | act;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_mem_latch: assert property (act != '0 |=> (memQ & $past(act)) == $past(act))
        else $error("activation not memorized");
    a_mem_hold: assert property (!memClr && memQ != '0 |=> (memQ & $past(memQ)) == $past(memQ))
        else $error("memorized bit lost without clear");
endmodule

// file: logic/rppa_core.sv
// top of the relay parameter access block: register port, password, settings, events
// assumes one-cycle strobes, never both at once, read data valid only the next cycle
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module rppa_core
    import rppa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [DW-1:0] rdData,
    input wire logic supplyFail,
    input wire logic panelSetWr,
    input wire logic [2:0] panelSetIdx,
    input wire logic [7:0] panelSetData,
    input wire logic panelPwdWr,
    input wire logic [9:0] panelPwdData,
    input wire logic [NSIG-1:0] sigAct,
    input wire logic [NMEAS-1:0][8:0] angleIn,
    input wire logic [NMEAS-1:0][12:0] pctIn,
    output logic [NSET-1:0][7:0] settingVal,
    output rppa_pstate_t pwdState,
    output logic [9:0] pwdStore,
    output logic [CNTW-1:0] evtCount
);
    rppa_pstate_t pState_r;
    logic [9:0] pwd_r;
    logic [2:0] fail_r;
    logic [7:0] set_r [NSET];
    logic [NSIG-1:0] mask_r;
    logic [DW-1:0] rdData_r;
    logic [DW-1:0] rdNxt;
    logic [NEVT-1:0] pend_r;
    logic [NEVT-1:0] pendSet;
    logic restPend_r;
    logic ovfPend_r;
    logic busOpen;
    logic busClose;
    logic busSetWr;
    logic memClr;
    logic evtPop;
    logic pwdMatch;
    logic [NSIG-1:0] actQ;
    logic [NSIG-1:0] memQ;
    logic [NSIG-1:0] rise;
    logic [NSIG-1:0] fall;
    logic [CW-1:0] headCode;
    logic [CNTW-1:0] count;
    logic full;
    logic empty;
    logic selValid;
    logic selSys;
    logic [CW-1:0] selCode;
    int selIdx;
    logic push;
    logic drop;

    // register port decode; the event mask address also takes writes, decoded at its register
    assign busOpen = wrStb && (addr == ADR_PWD_OPEN);
    assign busClose = wrStb && (addr == ADR_PWD_CLOSE);
    assign busSetWr = wrStb && rppaInWin(addr, ADR_SET_BASE, NSET);
    assign memClr = wrStb && (addr == ADR_STAT_MEM);
    assign evtPop = rdStb && (addr == ADR_EVT_DATA);
    assign pwdMatch = (wrData == {6'h00, pwd_r});

    assign rdData = rdData_r;
    assign pwdState = pState_r;
    assign pwdStore = pwd_r;
    assign evtCount = count;

    // settings outputs straight from their registers
    always_comb
    begin
        for (int i = 0; i < NSET; i++)
            settingVal[i] = set_r[i];
    end

    // signal flags, including the five relay bits and the breaker trip
    rppa_stat_latch uLatch (
        .mclk(mclk),
        .rst(rst),
        .act(sigAct),
        .memClr(memClr),
        .actQ(actQ),
        .memQ(memQ),
        .rise(rise),
        .fall(fall)
    );

    rppa_evt_buf uEvt (
        .mclk(mclk),
        .rst(rst),
        .push(push),
        .pushCode(selCode),
        .pop(evtPop),
        .headCode(headCode),
        .count(count),
        .full(full),
        .empty(empty)
    );

    // password state machine; supply failure outranks every command
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pState_r <= PW_CLOSED;
            pwd_r <= PWD_DEFAULT;
            fail_r <= '0;
        end
        else if (supplyFail)
        begin
            if (pState_r == PW_OPEN)
                pState_r <= PW_CLOSED;
        end
        else if (panelPwdWr)
        begin
            // the panel path is the only way out of lockout
            if (rppaPwdOk({6'h00, panelPwdData}))
            begin
                pwd_r <= panelPwdData;
                pState_r <= PW_CLOSED;
                fail_r <= '0;
            end
        end
        else if (busOpen)
        begin
            unique case (pState_r)
                PW_CLOSED, PW_OPEN:
                begin
                    if (pwdMatch)
                    begin
                        pState_r <= PW_OPEN;
                        fail_r <= '0;
                    end
                    else if (fail_r == FAIL_LIMIT - 3'h1)
                    begin
                        pState_r <= PW_LOCKED;
                        pwd_r <= PWD_LOCKVAL;
                        fail_r <= FAIL_LIMIT;
                    end
                    else
                    begin
                        pState_r <= PW_CLOSED;
                        fail_r <= fail_r + 3'h1;
                    end
                end
                PW_LOCKED:
                begin
                    // bus opening refused until the panel assigns a value
                end
                default:
                    pState_r <= PW_CLOSED;
            endcase
        end
        else if (busClose)
        begin
            if (pState_r == PW_OPEN)
            begin
                if (rppaPwdOk(wrData))
                    pwd_r <= wrData[9:0];
                pState_r <= PW_CLOSED;
            end
        end
    end

    // settings: panel writes need no password, bus writes need an open password
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NSET; i++)
                set_r[i] <= SET_RST[i];
        end
        else
        begin
            for (int i = 0; i < NSET; i++)
            begin
                if (panelSetWr && (panelSetIdx == 3'(i)))
                begin
                    if (rppaSetOk(i, {8'h00, panelSetData}))
                        set_r[i] <= panelSetData;
                end
                else if (busSetWr && (rppaWinIdx(addr, ADR_SET_BASE) == i))
                begin
                    // closed state or illegal value: dropped with no error reply
                    if (pState_r == PW_OPEN && rppaSetOk(i, wrData))
                        set_r[i] <= wrData[7:0];
                end
            end
        end
    end

    // event mask covers only signal edges; one bit per signal for both edges
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            mask_r <= MASK_RST;
        else if (wrStb && (addr == ADR_EVT_MASK))
            mask_r <= wrData[NSIG-1:0];
    end

    // masked signal edges: even code slot is activation, odd slot is reset
    always_comb
    begin
        pendSet = '0;
        for (int i = 0; i < NSIG; i++)
        begin
            pendSet[2*i] = rise[i] && mask_r[i];
            pendSet[2*i+1] = fall[i] && mask_r[i];
        end
    end

    // pick one event a cycle: system events first, then lowest pending slot
    always_comb
    begin
        selValid = 1'b0;
        selSys = 1'b0;
        selCode = '0;
        selIdx = 0;
        if (restPend_r)
        begin
            selValid = 1'b1;
            selSys = 1'b1;
            selCode = EVT_RESTART;
        end
        else if (ovfPend_r && !full)
        begin
            selValid = 1'b1;
            selSys = 1'b1;
            selCode = EVT_OVERFLOW;
        end
        else
        begin
            for (int i = NEVT - 1; i >= 0; i--)
            begin
                if (pend_r[i])
                begin
                    selValid = 1'b1;
                    selIdx = i;
                    selCode = CW'(i + 1);
                end
            end
        end
    end

    // a status event met by a full buffer is lost and flags overflow instead;
    // link codes fifty-two and up are never produced in this block
    assign push = selValid && !full;
    assign drop = selValid && full && !selSys;

    // pending slots: a new edge in the cycle its slot is taken is kept
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pend_r <= '0;
        else
        begin
            for (int i = 0; i < NEVT; i++)
            begin
                if ((push || drop) && !selSys && selIdx == i)
                    pend_r[i] <= pendSet[i];
                else
                    pend_r[i] <= pend_r[i] | pendSet[i];
            end
        end
    end

    // system events; restart is armed by reset itself
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            restPend_r <= 1'b1;
            ovfPend_r <= 1'b0;
        end
        else
        begin
            if (push && selCode == EVT_RESTART)
                restPend_r <= 1'b0;
            if (drop)
                ovfPend_r <= 1'b1;
            else if (push && selCode == EVT_OVERFLOW)
                ovfPend_r <= 1'b0;
        end
    end

    // read mux; password values are never readable
    always_comb
    begin
        rdNxt = '0;
        if (addr == ADR_PWD_STAT)
        begin
            rdNxt[POS_OPEN] = (pState_r == PW_OPEN);
            rdNxt[POS_LOCK] = (pState_r == PW_LOCKED);
            rdNxt[POS_FAIL +: 3] = fail_r;
        end
        else if (addr == ADR_EVT_DATA && !empty)
        begin
            rdNxt[POS_VALID] = 1'b1;
            rdNxt[CW-1:0] = headCode;
        end
        else if (addr == ADR_EVT_CNT)
            rdNxt[CNTW-1:0] = count;
        else if (addr == ADR_EVT_MASK)
            rdNxt[NSIG-1:0] = mask_r;
        else if (addr == ADR_STAT_ACT)
            rdNxt[NSIG-1:0] = actQ;
        else if (addr == ADR_STAT_MEM)
            rdNxt[NSIG-1:0] = memQ;
        else if (rppaInWin(addr, ADR_ANG_BASE, NMEAS))
        begin
            if (angleIn[rppaWinIdx(addr, ADR_ANG_BASE)] > ANGLE_MAX)
                rdNxt[8:0] = ANGLE_MAX;
            else
                rdNxt[8:0] = angleIn[rppaWinIdx(addr, ADR_ANG_BASE)];
        end
        else if (rppaInWin(addr, ADR_PCT_BASE, NMEAS))
        begin
            if (pctIn[rppaWinIdx(addr, ADR_PCT_BASE)] > PCT_MAX)
                rdNxt[12:0] = PCT_MAX;
            else
                rdNxt[12:0] = pctIn[rppaWinIdx(addr, ADR_PCT_BASE)];
        end
        else if (rppaInWin(addr, ADR_SET_BASE, NSET))
            rdNxt[7:0] = set_r[rppaWinIdx(addr, ADR_SET_BASE)];
    end

    // read data stands one cycle only; zero otherwise keeps stale data off the bus
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdData_r <= '0;
        else if (rdStb)
            rdData_r <= rdNxt;
        else
            rdData_r <= '0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_pwd_default: assert property (
        $past(rst) |-> pwd_r == PWD_DEFAULT)
        else $error("password not default after reset");
    a_open_match: assert property (
        busOpen && pwdMatch && pState_r == PW_CLOSED && !supplyFail && !panelPwdWr
        |=> pState_r == PW_OPEN && fail_r == 3'h0)
        else $error("matching password did not open");
    a_lock_seven: assert property (
        busOpen && !pwdMatch && pState_r != PW_LOCKED && fail_r == 3'h6
        && !supplyFail && !panelPwdWr
        |=> pState_r == PW_LOCKED && pwd_r == PWD_LOCKVAL)
        else $error("no lockout after seven wrong attempts");
    a_locked_stays: assert property (
        pState_r == PW_LOCKED && !panelPwdWr |=> pState_r == PW_LOCKED)
        else $error("lockout left without panel entry");
    a_close_cmd: assert property (
        busClose && !panelPwdWr |=> pState_r != PW_OPEN)
        else $error("close command left access open");
    a_supply_close: assert property (
        supplyFail |=> pState_r != PW_OPEN)
        else $error("supply failure left access open");
    a_pwd_change: assert property (
        busClose && pState_r == PW_OPEN && rppaPwdOk(wrData) && !supplyFail && !panelPwdWr
        |=> pwd_r == $past(wrData[9:0]))
        else $error("new password not stored");
    a_closed_hold: assert property (
        busSetWr && pState_r != PW_OPEN && !panelSetWr |=> settingVal == $past(settingVal))
        else $error("setting changed while closed");
    a_restart_evt: assert property (
        restPend_r && !full |=> !restPend_r && count != '0)
        else $error("restart event not queued");
    a_ovf_flag: assert property (
        drop |=> ovfPend_r)
        else $error("lost event did not flag overflow");
    a_angle_max: assert property (
        rdStb && rppaInWin(addr, ADR_ANG_BASE, NMEAS) |=> rdData_r <= {7'h00, ANGLE_MAX})
        else $error("angle reading above 359");
    a_pct_max: assert property (
        rdStb && rppaInWin(addr, ADR_PCT_BASE, NMEAS) |=> rdData_r <= {3'h0, PCT_MAX})
        else $error("percent reading above limit");

    for (genvar g = 0; g < NSET; g++)
    begin : gSetChk
        a_set_range: assert property (
            set_r[g] >= SET_MIN[g] && set_r[g] <= SET_MAX[g])
            else $error("setting outside permitted range");
    end

    c_open: cover property (busOpen ##1 pState_r == PW_OPEN);
    c_locked: cover property (pState_r == PW_LOCKED);
    c_overflow: cover property (drop ##[1:100] push && selCode == EVT_OVERFLOW);
    c_set_write: cover property (busSetWr && pState_r == PW_OPEN ##1 settingVal != $past(settingVal));
endmodule

// file: verification/rppa_bus_master.sv
// serial communicator model driving the register port
// assumes one-cycle strobes and read data in the cycle after rdStb
`timescale 1ns/1ps
module rppa_bus_master
    import rppa_pkg::*;
(
    input wire logic mclk,
    input wire logic [DW-1:0] rdData,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] wrData,
    output logic wrStb,
    output logic rdStb
);
    // idle bus at time zero; link fault event codes belong to this side, none are sent
    initial {addr, wrData, wrStb, rdStb} = '0;

    // open, close and change all travel as plain writes
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
        wrData <= ~d; // released data must not look valid
        #1;
    endtask

    // read data is taken one cycle after the strobe
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1 d = rdData;
    endtask
endmodule

// file: verification/rppa_core_test.sv
// self-checking bench with an integer model of the password and settings
// assumes the register map and codes of rppa_pkg
`timescale 1ns/1ps
module rppa_core_test;
    import rppa_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic supplyFail = 1'b0;
    logic panelPwdWr = 1'b0;
    logic [9:0] panelPwdData = '0;
    logic panelSetWr = 1'b0;
    logic [2:0] panelSetIdx = '0;
    logic [7:0] panelSetData = '0;
    logic [NSIG-1:0] sigAct = '0;
    logic [NMEAS-1:0][8:0] angleIn = '0;
    logic [NMEAS-1:0][12:0] pctIn = '0;
    logic [AW-1:0] addr;
    logic [DW-1:0] wrData;
    logic [DW-1:0] rdData;
    logic [DW-1:0] got;
    logic wrStb;
    logic rdStb;
    logic [NSET-1:0][7:0] settingVal;
    rppa_pstate_t pwdState;
    logic [9:0] pwdStore;
    logic [CNTW-1:0] evtCount;
    logic [31:0] rs = 32'h0000_f6da;
    int n_fail = 0;
    int total_checks = 0;
    int mPwd = 1;
    int mOpen = 0;
    int mLock = 0;
    int mFail = 0;
    int mSet [NSET];
    int expQ [$];
    int nEvt = 0;
    logic [DW-1:0] evt0 = '0;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    rppa_bus_master rppa_bus_master_i (.mclk(mclk), .rdData(rdData), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb));
    rppa_core rppa_core_i (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .supplyFail(supplyFail),
        .panelSetWr(panelSetWr), .panelSetIdx(panelSetIdx), .panelSetData(panelSetData),
        .panelPwdWr(panelPwdWr), .panelPwdData(panelPwdData), .sigAct(sigAct),
        .angleIn(angleIn), .pctIn(pctIn), .settingVal(settingVal),
        .pwdState(pwdState), .pwdStore(pwdStore), .evtCount(evtCount));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bus write, then the model's view of the same write
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        int i;
        i = int'(a) - int'(ADR_SET_BASE);
        rppa_bus_master_i.wr(a, d);
        if (a == ADR_PWD_OPEN && mLock == 0)
        begin
            mOpen = int'(int'(d) == mPwd);
            mFail = mOpen ? 0 : mFail + 1;
            mLock = int'(mFail == 7);
            mPwd = mLock ? 0 : mPwd;
        end
        else if (a == ADR_PWD_CLOSE && mOpen != 0)
        begin
            mOpen = 0;
            mPwd = (d >= PWD_MIN && d <= PWD_MAX) ? int'(d) : mPwd;
        end
        else if (i >= 0 && i < NSET && mOpen != 0 && d >= SET_MIN[i] && d <= SET_MAX[i])
            mSet[i] = int'(d);
    endtask

    // model password state, stored password and settings against the design
    task automatic cmpAll();
        check(16'(pwdState), 16'(mLock ? PW_LOCKED : mOpen ? PW_OPEN : PW_CLOSED));
        check(16'(pwdStore), 16'(mPwd));
        foreach (mSet[i]) check(16'(settingVal[i]), 16'(mSet[i]));
    endtask

    task automatic rdChk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        rppa_bus_master_i.rd(a, got);
        check(got, exp);
    endtask

    // panel setting entry needs no password but is still range checked
    task automatic panelSet(input int idx, input logic [7:0] d);
        @(posedge mclk);
        panelSetIdx <= 3'(idx);
        panelSetData <= d;
        panelSetWr <= 1'b1;
        @(posedge mclk);
        panelSetWr <= 1'b0;
        #1;
        if (d >= SET_MIN[idx] && d <= SET_MAX[idx])
            mSet[idx] = int'(d);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // under two hundred clock cycles are expected; 10,000 cycles, over fifty times that, is a hang
    initial
    begin
        #400_000;
        n_fail++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        foreach (mSet[i]) mSet[i] = int'(SET_RST[i]);
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 cmpAll();
        check(16'(evtCount), 16'h0001);
        rdChk(ADR_EVT_DATA, 16'h0132);
        wr(ADR_SET_BASE, 16'h0014);
        cmpAll();
        wr(ADR_PWD_OPEN, 16'h0001);
        cmpAll();
        // random values, many of them outside the legal ranges
        for (int k = 0; k < 20; k++)
        begin
            rs = xs(rs);
            wr(ADR_SET_BASE + 8'(k % NSET), {10'h000, rs[5:0]});
            cmpAll();
        end
        wr(ADR_PWD_CLOSE, 16'h007b);
        cmpAll();
        wr(ADR_SET_BASE + 8'h01, 16'h001e);
        wr(ADR_PWD_OPEN, 16'h007b);
        supplyFail <= 1'b1;
        @(posedge mclk);
        supplyFail <= 1'b0;
        @(posedge mclk);
        #1 mOpen = 0;
        cmpAll();
        // six wrong, one right, then seven wrong in a row
        for (int k = 0; k < 14; k++)
        begin
            wr(ADR_PWD_OPEN, k == 6 ? 16'h007b : 16'h01f4);
            cmpAll();
        end
        wr(ADR_PWD_OPEN, 16'h0000);
        cmpAll();
        rdChk(ADR_PWD_STAT, 16'((mFail << 2) | (mLock << 1) | mOpen));
        panelPwdData <= 10'h005;
        panelPwdWr <= 1'b1;
        @(posedge mclk);
        panelPwdWr <= 1'b0;
        @(posedge mclk);
        #1 {mLock, mFail, mPwd} = {32'h0, 32'h0, 32'h5};
        cmpAll();
        // random panel entries, legal and illegal alike
        for (int k = 0; k < 2 * NSET; k++)
        begin
            rs = xs(rs);
            panelSet(k % NSET, {2'b00, rs[5:0]});
            cmpAll();
        end
        rs = xs(rs);
        sigAct <= rs[8:0];
        nEvt = 2 * $countones(rs[8:0]);
        for (int j = NSIG - 1; j >= 0; j--)
            if (rs[j]) evt0 = 16'h0100 | 16'(2 * j + 1);
        repeat (3) @(posedge mclk);
        rdChk(ADR_STAT_ACT, 16'(rs[8:0]));
        sigAct <= '0;
        repeat (3) @(posedge mclk);
        rdChk(ADR_STAT_MEM, 16'(rs[8:0]));
        wr(ADR_STAT_MEM, 16'h0000);
        rdChk(ADR_STAT_MEM, 16'h0000);
        for (int k = 0; k < NMEAS; k++)
        begin
            rs = xs(rs);
            angleIn[k] <= rs[8:0];
            pctIn[k] <= rs[28:16];
            expQ.push_back(rs[8:0] > 359 ? 359 : int'(rs[8:0]));
            expQ.push_back(rs[28:16] > 6554 ? 6554 : int'(rs[28:16]));
        end
        for (int k = 0; k < NMEAS; k++)
        begin
            rdChk(ADR_ANG_BASE + 8'(k), 16'(expQ.pop_front()));
            rdChk(ADR_PCT_BASE + 8'(k), 16'(expQ.pop_front()));
        end
        check(16'(evtCount), 16'(nEvt));
        rdChk(ADR_EVT_DATA, evt0);
        print_verdict();
    end
endmodule
